// ===== rtl/eel_top.v
// Edge event line controller: nineteen edge lines, masks, pending bits,
// interrupt and event requests, and a Wishbone register slave.
// Assumes clk_i is the peripheral bus clock and rst_i a synchronous
// system reset; pins and internal sources may be asynchronous.
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "eel_regs.vh"
module eel_top (
   input  wire                   clk_i,
   input  wire                   rst_i,
   input  wire                   wb_cyc_i,
   input  wire                   wb_stb_i,
   input  wire                   wb_we_i,
   input  wire [`EEL_ADR_W-1:0]  wb_adr_i,
   input  wire [3:0]             wb_sel_i,
   input  wire [31:0]            wb_dat_i,
   output reg  [31:0]            wb_dat_o,
   output reg                    wb_ack_o,
   input  wire [`EEL_PINS-1:0]   pins_i,
   input  wire                   supply_level_detector_i,
   input  wire                   clock_alarm_i,
   input  wire                   bus_wakeup_i,
   output reg  [`EEL_LINES-1:0]  irq_o,
   output reg  [`EEL_LINES-1:0]  evt_o,
   output wire                   wake_o
);
   reg  [`EEL_LINES-1:0]                   irq_mask_q;
   reg  [`EEL_LINES-1:0]                   irq_mask_d;
   reg  [`EEL_LINES-1:0]                   evt_mask_q;
   reg  [`EEL_LINES-1:0]                   evt_mask_d;
   reg  [`EEL_LINES-1:0]                   rise_q;
   reg  [`EEL_LINES-1:0]                   rise_d;
   reg  [`EEL_LINES-1:0]                   fall_q;
   reg  [`EEL_LINES-1:0]                   fall_d;
   reg  [`EEL_LINES-1:0]                   pend_q;
   reg  [`EEL_LINES-1:0]                   pend_d;
   reg  [`EEL_LINES-1:0]                   swtrig_q;
   reg  [`EEL_LINES-1:0]                   swtrig_d;
   reg  [`EEL_PIN_LINES*`EEL_SEL_W-1:0]    psel_q;
   reg  [`EEL_PIN_LINES*`EEL_SEL_W-1:0]    psel_d;
   reg  [31:0]                             rdata_d;
   reg  [31:0]                             pend_clr;
   wire [`EEL_LINES-1:0]                   src;
   wire [`EEL_LINES-1:0]                   hit;
   wire [`EEL_LINES-1:0]                   armed;
   wire [`EEL_LINES-1:0]                   trig;
   wire [31:0]                             wmask;
   wire                                    req;
   wire                                    wr;
   integer                                 r;
   integer                                 j;

   // One access per request; ack falls in the cycle after it was given.
   assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr    = req & wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Pin-fed lines each pick one port pin through their own selector.
   genvar g;
   generate
      for (g = 0; g < `EEL_PIN_LINES; g = g + 1) begin : g_pin
         eel_port_sel #(
            .LINE (g)
         ) u_sel (
            .pins_i (pins_i),
            .sel_i  (psel_q[g*`EEL_SEL_W +: `EEL_SEL_W]),
            .pin_o  (src[g])
         );
      end
   endgenerate

   assign src[`EEL_LINE_SUPPLY] = supply_level_detector_i;
   assign src[`EEL_LINE_ALARM]  = clock_alarm_i;
   assign src[`EEL_LINE_WAKEUP] = bus_wakeup_i;

   // Each line has its own catcher, so lines never disturb each other.
   generate
      for (g = 0; g < `EEL_LINES; g = g + 1) begin : g_line
         eel_edge_catch u_catch (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .sig_i     (src[g]),
            .rise_en_i (rise_q[g]),
            .fall_en_i (fall_q[g]),
            .hit_o     (hit[g]),
            .armed_o   (armed[g])
         );
      end
   endgenerate

   // Wake needs no running clock: it is formed from the catcher flops
   // directly, which is why it is the one output not taken from a
   // clocked register.
   assign wake_o = |(armed & (irq_mask_q | evt_mask_q));

   // A software trigger behaves as a detected edge on that line.
   assign trig = hit | swtrig_q;

   always @* begin
      irq_mask_d = irq_mask_q;
      evt_mask_d = evt_mask_q;
      rise_d     = rise_q;
      fall_d     = fall_q;
      psel_d     = psel_q;
      swtrig_d   = {`EEL_LINES{1'b0}};
      pend_clr   = `EEL_ZERO32;
      if (wr) begin
         case (wb_adr_i)
            `EEL_OFS_IRQ_MASK: begin
               irq_mask_d = irq_mask_q & ~wmask[`EEL_LINES-1:0]
                          | wb_dat_i[`EEL_LINES-1:0]
                          & wmask[`EEL_LINES-1:0];
            end
            `EEL_OFS_EVT_MASK: begin
               evt_mask_d = evt_mask_q & ~wmask[`EEL_LINES-1:0]
                          | wb_dat_i[`EEL_LINES-1:0]
                          & wmask[`EEL_LINES-1:0];
            end
            `EEL_OFS_RISE_SEL: begin
               rise_d = rise_q & ~wmask[`EEL_LINES-1:0]
                      | wb_dat_i[`EEL_LINES-1:0]
                      & wmask[`EEL_LINES-1:0];
            end
            `EEL_OFS_FALL_SEL: begin
               fall_d = fall_q & ~wmask[`EEL_LINES-1:0]
                      | wb_dat_i[`EEL_LINES-1:0]
                      & wmask[`EEL_LINES-1:0];
            end
            `EEL_OFS_SW_TRIG: begin
               swtrig_d = wb_dat_i[`EEL_LINES-1:0]
                        & wmask[`EEL_LINES-1:0];
            end
            `EEL_OFS_PENDING: begin
               pend_clr = wb_dat_i & wmask;
            end
            `EEL_OFS_PSEL0,
            `EEL_OFS_PSEL1,
            `EEL_OFS_PSEL2,
            `EEL_OFS_PSEL3: begin
               for (r = 0; r < `EEL_PSEL_REGS; r = r + 1) begin
                  if (wb_adr_i == `EEL_OFS_PSEL0 + r * 4) begin
                     for (j = 0; j < `EEL_LINES_PER_PSEL; j = j + 1) begin
                        if (wb_sel_i[j/2]) begin
                           psel_d[(r*`EEL_LINES_PER_PSEL+j)*`EEL_SEL_W
                                  +: `EEL_SEL_W] =
                              wb_dat_i[j*`EEL_PSEL_FIELD_W
                                       +: `EEL_SEL_W];
                        end
                     end
                  end
               end
            end
            default: begin
               pend_clr = `EEL_ZERO32;
            end
         endcase
      end
   end

   // A new trigger in the same cycle as its clear keeps the bit set.
   always @* begin
      pend_d = pend_q & ~pend_clr[`EEL_LINES-1:0] | trig;
   end

   always @* begin
      rdata_d = `EEL_ZERO32;
      case (wb_adr_i)
         `EEL_OFS_IRQ_MASK: begin
            rdata_d[`EEL_LINES-1:0] = irq_mask_q;
         end
         `EEL_OFS_EVT_MASK: begin
            rdata_d[`EEL_LINES-1:0] = evt_mask_q;
         end
         `EEL_OFS_RISE_SEL: begin
            rdata_d[`EEL_LINES-1:0] = rise_q;
         end
         `EEL_OFS_FALL_SEL: begin
            rdata_d[`EEL_LINES-1:0] = fall_q;
         end
         `EEL_OFS_PENDING: begin
            rdata_d[`EEL_LINES-1:0] = pend_q;
         end
         `EEL_OFS_PSEL0,
         `EEL_OFS_PSEL1,
         `EEL_OFS_PSEL2,
         `EEL_OFS_PSEL3: begin
            for (r = 0; r < `EEL_PSEL_REGS; r = r + 1) begin
               if (wb_adr_i == `EEL_OFS_PSEL0 + r * 4) begin
                  for (j = 0; j < `EEL_LINES_PER_PSEL; j = j + 1) begin
                     rdata_d[j*`EEL_PSEL_FIELD_W +: `EEL_SEL_W] =
                        psel_q[(r*`EEL_LINES_PER_PSEL+j)*`EEL_SEL_W
                               +: `EEL_SEL_W];
                  end
               end
            end
         end
         default: begin
            rdata_d = `EEL_ZERO32;
         end
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_q <= `EEL_RST_MASK;
         evt_mask_q <= `EEL_RST_MASK;
         rise_q     <= `EEL_RST_EDGE;
         fall_q     <= `EEL_RST_EDGE;
         psel_q     <= `EEL_RST_PSEL;
         swtrig_q   <= `EEL_RST_MASK;
         pend_q     <= `EEL_RST_MASK;
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= `EEL_ZERO32;
         irq_o      <= `EEL_RST_MASK;
         evt_o      <= `EEL_RST_MASK;
      end else begin
         irq_mask_q <= irq_mask_d;
         evt_mask_q <= evt_mask_d;
         rise_q     <= rise_d;
         fall_q     <= fall_d;
         psel_q     <= psel_d;
         swtrig_q   <= swtrig_d;
         pend_q     <= pend_d;
         wb_ack_o   <= req;
         wb_dat_o   <= req ? rdata_d : `EEL_ZERO32;
         irq_o      <= pend_d & irq_mask_d;
         evt_o      <= trig & evt_mask_q;
      end
   end
endmodule // eel_top

// ===== rtl/eel_regs.vh
// Constants for the edge event line controller: sizes, register offsets
// and reset values.
// Assumes a 32-bit classic Wishbone slave port with byte selects.
`ifndef EEL_REGS_VH
`define EEL_REGS_VH

`define EEL_LINES        19
`define EEL_PIN_LINES    16
`define EEL_PINS         80
`define EEL_PORTS        5
`define EEL_SEL_W        3
`define EEL_IDX_W        7
`define EEL_LINE_SUPPLY  16
`define EEL_LINE_ALARM   17
`define EEL_LINE_WAKEUP  18

`define EEL_ADR_W        8
`define EEL_OFS_IRQ_MASK 8'h00
`define EEL_OFS_EVT_MASK 8'h04
`define EEL_OFS_RISE_SEL 8'h08
`define EEL_OFS_FALL_SEL 8'h0C
`define EEL_OFS_SW_TRIG  8'h10
`define EEL_OFS_PENDING  8'h14
`define EEL_OFS_PSEL0    8'h18
`define EEL_OFS_PSEL1    8'h1C
`define EEL_OFS_PSEL2    8'h20
`define EEL_OFS_PSEL3    8'h24

`define EEL_LINES_PER_PSEL 4
`define EEL_PSEL_FIELD_W   4
`define EEL_PSEL_REGS      4

`define EEL_RST_MASK     19'h00000
`define EEL_RST_EDGE     19'h00000
`define EEL_RST_PSEL     48'h000000000000
`define EEL_ZERO32       32'h00000000

`endif

// ===== rtl/eel_port_sel.v
// Picks the pin that feeds one pin-fed line: port number times sixteen
// plus the line number.
// Assumes pins are packed port by port, sixteen pins per port.
`timescale 1ns/1ns
`include "eel_regs.vh"
module eel_port_sel #(
   parameter LINE = 0
) (
   input  wire [`EEL_PINS-1:0]  pins_i,
   input  wire [`EEL_SEL_W-1:0] sel_i,
   output reg                   pin_o
);
   localparam [`EEL_IDX_W-1:0] LINE_IDX = LINE;
   localparam [`EEL_SEL_W-1:0] PORTS    = `EEL_PORTS;
   reg [`EEL_IDX_W-1:0] idx;

   always @* begin
      idx   = {sel_i, 4'h0} + LINE_IDX;
      pin_o = 1'b0;
      if (sel_i < PORTS) begin
         pin_o = pins_i[idx];
      end
   end
endmodule // eel_port_sel

// ===== rtl/eel_edge_catch.v
// Asynchronous edge catcher for one line with a two-stage synchroniser
// and a clear handshake back from the clock domain.
// Assumes the edge enables change only while the line is quiet.
`timescale 1ns/1ns
`include "eel_regs.vh"
module eel_edge_catch (
   input  wire clk_i,
   input  wire rst_i,
   input  wire sig_i,
   input  wire rise_en_i,
   input  wire fall_en_i,
   output reg  hit_o,
   output wire armed_o
);
   reg  rise_q;
   reg  fall_q;
   reg  meta_q;
   reg  sync_q;
   reg  seen_q;
   reg  clr_q;
   wire clr;

   // Edges that come while the clear is still held are merged into the
   // capture just taken; back-to-back pulses closer than about six
   // clock cycles count once.
   assign clr     = rst_i | clr_q;
   assign armed_o = rise_q | fall_q;

   always @(posedge sig_i or posedge clr) begin
      if (clr) begin
         rise_q <= 1'b0;
      end else if (rise_en_i) begin
         rise_q <= 1'b1;
      end
   end

   always @(negedge sig_i or posedge clr) begin
      if (clr) begin
         fall_q <= 1'b0;
      end else if (fall_en_i) begin
         fall_q <= 1'b1;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         seen_q <= 1'b0;
         clr_q  <= 1'b0;
         hit_o  <= 1'b0;
      end else begin
         meta_q <= rise_q | fall_q;
         sync_q <= meta_q;
         seen_q <= sync_q;
         clr_q  <= sync_q;
         hit_o  <= sync_q & ~seen_q;
      end
   end
endmodule // eel_edge_catch

// ===== sim/eel_properties.sv
// Checker on the controller's top-level ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module eel_properties (
   input wire        clk_i,
   input wire        rst_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire [18:0] irq_o,
   input wire [18:0] evt_o,
   input wire        wake_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_one;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack late");
   property p_ack_gap;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_gap: assert property (p_ack_gap) else $error("ack long");
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h00000000;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("data idle");
   property p_evt_pulse;
      evt_o != 19'h00000 |=> (evt_o & $past(evt_o)) == 19'h00000;
   endproperty
   a_evt_pulse: assert property (p_evt_pulse) else $error("evt long");
   // Pending only leaves by a write, so irq can only fall at a write ack.
   property p_irq_hold;
      ($past(irq_o) & ~irq_o) != 19'h00000 |-> wb_ack_o && $past(wb_we_i);
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq fell");
   property p_rst;
      $past(rst_i) |-> irq_o == 19'h00000 && evt_o == 19'h00000 && !wake_o;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values");
   property p_wake;
      $rose(wake_o) |-> ##[0:6] (irq_o != 19'h00000 || evt_o != 19'h00000);
   endproperty
   a_wake: assert property (p_wake) else $error("wake lost");
endmodule // eel_properties

bind eel_top eel_properties eel_properties_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .irq_o(irq_o), .evt_o(evt_o), .wake_o(wake_o));

// ===== sim/eel_src_model.sv
// Source model: eighty pins and the three internal line sources.
// Assumes the bench calls its tasks away from clock edges.
`timescale 1ns/1ns
module eel_src_model (
   output wire [79:0] pins_o,
   output wire        supply_o,
   output wire        alarm_o,
   output wire        wakeup_o
);
   reg [82:0] src_q = 83'h0;
   assign pins_o   = src_q[79:0];
   assign supply_o = src_q[80];
   assign alarm_o  = src_q[81];
   assign wakeup_o = src_q[82];
   task step(input integer idx);
      src_q[idx] = ~src_q[idx];
   endtask
   // Narrower than a clock period, so only an asynchronous catch sees it.
   task glitch(input integer idx);
      src_q[idx] = ~src_q[idx];
      #2;
      src_q[idx] = ~src_q[idx];
   endtask
endmodule // eel_src_model

// ===== sim/tb_edge_event_line_controller.sv
// Bench: registers, edge choices, masks and pending bits of every line.
// Assumes the source model and the bound checker.
`timescale 1ns/1ns
`include "eel_regs.vh"
module tb_edge_event_line_controller;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         cyc = 1'b0, stb = 1'b0, we = 1'b0;
   reg  [7:0]  adr = 8'h00;
   reg  [31:0] dat = 32'h00000000;
   reg  [31:0] v;
   reg  [3:0]  sel = 4'hF;
   wire [31:0] rdat;
   wire        ack, wake, sup, alm, wku;
   wire [18:0] irq, evt;
   wire [79:0] pins;
   integer     miscompares = 0, comparisons = 0, evt_seen = 0, evt_exp = 0;
   integer     i, k, m, src, dr;
   eel_top eel_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .pins_i(pins),
      .supply_level_detector_i(sup), .clock_alarm_i(alm),
      .bus_wakeup_i(wku), .irq_o(irq), .evt_o(evt), .wake_o(wake));
   eel_src_model eel_src_model_inst (.pins_o(pins), .supply_o(sup),
      .alarm_o(alm), .wakeup_o(wku));
   initial forever #2 clk_i = ~clk_i;
   always @(posedge clk_i) evt_seen <= evt_seen + $countones(evt);
   task finish_test;
      if (miscompares == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string n, input [31:0] e, input [31:0] g);
      comparisons = comparisons + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0s expected %h seen %h", n, e, g);
      end
   endtask
   task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task wr(input [7:0] a, input [31:0] d);
      reg [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task rc(input string n, input [7:0] a, input [31:0] e);
      reg [31:0] q;
      wb(1'b0, a, 32'h00000000, q);
      chk(n, e, q);
   endtask
   function [31:0] exp_pend(input integer ln, md, d);
      exp_pend = (d == 2 || (d == 0 && md[0]) || (d == 1 && md[1])) ?
                 (32'h1 << ln) : 32'h0;
   endfunction
   initial begin
      #80000;
      miscompares = miscompares + 1;
      finish_test;
   end
   initial begin
      v = $urandom(22794);
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rc("irq_mask", `EEL_OFS_IRQ_MASK, 32'h0);
      v = $urandom;
      wr(`EEL_OFS_RISE_SEL, v);
      rc("rise_sel", `EEL_OFS_RISE_SEL, v & 32'h7FFFF);
      sel <= 4'h1;
      wr(`EEL_OFS_RISE_SEL, 32'hFFFFFFFF);
      sel <= 4'hF;
      rc("rise_byte", `EEL_OFS_RISE_SEL, v & 32'h7FF00 | 32'hFF);
      rc("sw_trig", `EEL_OFS_SW_TRIG, 32'h0);
      rc("unmapped", 8'hFC, 32'h0);
      wr(`EEL_OFS_SW_TRIG, 32'h8);
      rc("pend_sw", `EEL_OFS_PENDING, 32'h8);
      chk("irq_off", 32'h0, {13'h0000, irq});
      wr(`EEL_OFS_PENDING, 32'h0);
      rc("pend_keep", `EEL_OFS_PENDING, 32'h8);
      wr(`EEL_OFS_PENDING, 32'h8);
      rc("pend_clr", `EEL_OFS_PENDING, 32'h0);
      for (i = 0; i < 19; i = i + 1) begin
         m = i % 3 + 1;
         k = $urandom % 5;
         src = (i < 16) ? 16 * k + i : 64 + i;
         wr(`EEL_OFS_PSEL0 + 4 * (i / 4), k << (4 * (i % 4)));
         wr(`EEL_OFS_RISE_SEL, (m & 1) << i);
         wr(`EEL_OFS_FALL_SEL, (m >> 1) << i);
         wr(`EEL_OFS_EVT_MASK, (i % 2 == 0) << i);
         wr(`EEL_OFS_IRQ_MASK, 32'h1 << i);
         for (dr = 0; dr < 3; dr = dr + 1) begin
            @(posedge clk_i);
            #1;
            if (dr == 2)
               eel_src_model_inst.glitch(src);
            else
               eel_src_model_inst.step(src);
            v = exp_pend(i, m, dr);
            @(posedge clk_i);
            #1;
            chk("wake", v != 0, {31'h00000000, wake});
            repeat (7) @(posedge clk_i);
            #1;
            if (i % 2 == 0 && v != 0)
               evt_exp = evt_exp + 1;
            chk("irq", v, {13'h0000, irq});
            rc("pending", `EEL_OFS_PENDING, v);
            wr(`EEL_OFS_PENDING, v);
         end
      end
      chk("evt_count", evt_exp, evt_seen);
      finish_test;
   end
endmodule // tb_edge_event_line_controller
